/* File: low_power_mode_sequencer.sv */
// Notes on behaviour
// - code 0x1 selects deep sleep
// - code 0x2 selects power-down
// - code 0x3 selects deep power-down
// - wake restores wake power config
// - enabled pin interrupts wake the part
// - brownout wakes only if kept powered
// - watchdog wakes only if oscillator runs
// - usb and gpio group also wake
// - power-down stops cpu and periph clocks, rc, flash
// - deep sleep keeps state, pins static
// - deep power-down tristates all but wake
// - disable bit blocks deep power-down
// - wake falling edge ramps then resets
// - only retention registers survive
// - flag marks deep power-down wake
// - reset pin ignored in deep power-down
// - code 0x0 without request is sleep
// - deep sleep gates rc output, flash standby
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_sequencer
	import lpm_seq_pkg::*;
#(
	parameter int PINS    = 8,
	parameter int RETAIN_W = 32,
	parameter int POR_CYC = POR_DELAY_CYC
) (
	// clock and reset
	input  wire logic                CLOCK_IN,
	input  wire logic                SRST_IN,
	input  wire logic                EXT_RESET_IN,
	// power control register writes
	input  wire logic                CTRL_WR_IN,
	input  wire logic [1:0]          POWER_MODE_IN,
	input  wire logic                DPD_DISABLE_IN,
	input  wire logic                DPD_FLAG_CLR_IN,
	// configuration
	input  wire logic [CFG_WIDTH-1:0] SLEEP_CFG_IN,
	input  wire logic [CFG_WIDTH-1:0] WAKE_CFG_IN,
	input  wire logic                WDT_LOCK_IN,
	input  wire logic                WDT_CLK_IS_RC_IN,
	// core handshake
	input  wire logic                DEEP_SLEEP_REQ_IN,
	input  wire logic                WAIT_INT_IN,
	input  wire logic                IRQ_PENDING_IN,
	// wake sources
	input  wire logic [PINS-1:0]     PIN_INT_IN,
	input  wire logic [PINS-1:0]     PIN_WAKE_ENABLE_IN,
	input  wire logic [PINS-1:0]     PIN_IRQ_EN_IN,
	input  wire logic                BROWNOUT_EVENT_IN,
	input  wire logic                BROWNOUT_INT_EN_IN,
	input  wire logic                BROWNOUT_RST_EN_IN,
	input  wire logic                WDT_EVENT_IN,
	input  wire logic                WDT_INT_MODE_IN,
	input  wire logic                WDT_RESET_MODE_IN,
	input  wire logic                USB_WAKE_IN,
	input  wire logic                GPIO_GROUP_IN,
	input  wire logic [1:0]          WAKE_REG1_EN_IN,
	input  wire logic                WAKE_PIN_IN,
	// retention registers
	input  wire logic                RETAIN_WR_IN,
	input  wire logic [1:0]          RETAIN_IDX_IN,
	input  wire logic [RETAIN_W-1:0] RETAIN_DATA_IN,
	// status
	output logic [1:0]               POWER_MODE_OUT,
	output logic                     DPD_DISABLE_OUT,
	output logic                     DPD_FLAG_OUT,
	output logic [2:0]               STATE_OUT,
	output logic [RETAIN_W-1:0]      RETAIN_RD_OUT,
	// clock and power gating
	output logic                     CPU_CLK_EN_OUT,
	output logic                     PERIPH_CLK_EN_OUT,
	output logic                     WDT_CLK_EN_OUT,
	output logic                     RC_OSC_ON_OUT,
	output logic                     RC_OUT_EN_OUT,
	output logic                     FLASH_ON_OUT,
	output logic                     FLASH_STANDBY_OUT,
	output logic [CFG_WIDTH-1:0]     ANALOG_CFG_OUT,
	output logic                     PIN_HOLD_OUT,
	output logic                     PIN_TRISTATE_OUT,
	output logic                     CORE_REG_ON_OUT,
	output logic                     SYS_RESET_OUT
);

	// ----------------------------------------
	// state record
	// ----------------------------------------
	typedef struct packed {
		lpm_state_e               state;
		logic [1:0]               mode;
		logic                     dpd_dis;
		logic                     dpd_flag;
		logic                     wake_prev;
		logic [15:0]              por_cnt;
		logic [RETAIN_W-1:0]      retain0;
		logic [RETAIN_W-1:0]      retain1;
		logic [RETAIN_W-1:0]      retain2;
		logic [RETAIN_W-1:0]      retain3;
		logic [RETAIN_W-1:0]      rd;
		logic                     cpu_clk;
		logic                     per_clk;
		logic                     wdt_clk;
		logic                     rc_on;
		logic                     rc_out;
		logic                     fl_on;
		logic                     fl_stby;
		logic [CFG_WIDTH-1:0]     analog;
		logic                     hold;
		logic                     tri_st;
		logic                     reg_on;
		logic                     sys_rst;
	} lpm_s;

	lpm_s state_ff;
	lpm_s nxt_state;
	logic wake_any;

	// ----------------------------------------
	// wake source combining
	// ----------------------------------------
	lpm_wake_detect #(
		.PINS(PINS)
	) u_wake (
		.pin_int_in        (PIN_INT_IN),
		.pin_wake_enable_in(PIN_WAKE_ENABLE_IN),
		.pin_irq_en_in     (PIN_IRQ_EN_IN),
		.brownout_event_in (BROWNOUT_EVENT_IN),
		.brownout_int_en_in(BROWNOUT_INT_EN_IN),
		.brownout_rst_en_in(BROWNOUT_RST_EN_IN),
		.wdt_event_in      (WDT_EVENT_IN),
		.wdt_int_mode_in   (WDT_INT_MODE_IN),
		.wdt_reset_mode_in (WDT_RESET_MODE_IN),
		.usb_wake_in       (USB_WAKE_IN),
		.gpio_group_in     (GPIO_GROUP_IN),
		.wake_reg1_en_in   (WAKE_REG1_EN_IN),
		.sleep_cfg_in      (SLEEP_CFG_IN),
		.wake_out          (wake_any)
	);

	function automatic logic [RETAIN_W-1:0] pick_retain(input lpm_s s, input logic [1:0] idx);
		logic [RETAIN_W-1:0] v;
		v = s.retain0;
		if (idx == 2'h1) begin
			v = s.retain1;
		end else if (idx == 2'h2) begin
			v = s.retain2;
		end else if (idx == 2'h3) begin
			v = s.retain3;
		end
		return v;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.wake_prev = WAKE_PIN_IN;
		nxt_state.sys_rst = 1'b0;
		if (RETAIN_WR_IN) begin
			case (RETAIN_IDX_IN)
				2'h0: nxt_state.retain0 = RETAIN_DATA_IN;
				2'h1: nxt_state.retain1 = RETAIN_DATA_IN;
				2'h2: nxt_state.retain2 = RETAIN_DATA_IN;
				default: nxt_state.retain3 = RETAIN_DATA_IN;
			endcase
		end
		nxt_state.rd = pick_retain(state_ff, RETAIN_IDX_IN);
		if (CTRL_WR_IN) begin
			nxt_state.mode = POWER_MODE_IN;
			nxt_state.dpd_dis = DPD_DISABLE_IN;
		end
		if (DPD_FLAG_CLR_IN) begin
			nxt_state.dpd_flag = 1'b0;
		end
		case (state_ff.state)
			ST_ACTIVE: begin
				nxt_state.cpu_clk = 1'b1;
				nxt_state.per_clk = 1'b1;
				nxt_state.wdt_clk = 1'b1;
				nxt_state.rc_on = 1'b1;
				nxt_state.rc_out = 1'b1;
				nxt_state.fl_on = 1'b1;
				nxt_state.fl_stby = 1'b0;
				nxt_state.hold = 1'b0;
				if (WAIT_INT_IN) begin
					nxt_state.cpu_clk = 1'b0;
					if (!DEEP_SLEEP_REQ_IN || state_ff.mode == MODE_SLEEP) begin
						nxt_state.state = ST_SLEEP;
					end else if (state_ff.mode == MODE_DEEP_SLEEP) begin
						nxt_state.state = ST_DEEP_SLEEP;
						nxt_state.per_clk = 1'b0;
						nxt_state.wdt_clk = ~SLEEP_CFG_IN[CFG_WDOSC_OFF] |
							(WDT_LOCK_IN & WDT_CLK_IS_RC_IN);
						// rc stays up, output gated, flash standby
						nxt_state.rc_out = 1'b0;
						nxt_state.fl_stby = 1'b1;
						nxt_state.analog = SLEEP_CFG_IN;
						nxt_state.hold = 1'b1;
					end else if (state_ff.mode == MODE_POWER_DOWN ||
						state_ff.dpd_dis) begin
						nxt_state.state = ST_POWER_DOWN;
						nxt_state.per_clk = 1'b0;
						nxt_state.wdt_clk = ~SLEEP_CFG_IN[CFG_WDOSC_OFF];
						nxt_state.rc_on = 1'b0;
						nxt_state.rc_out = 1'b0;
						nxt_state.fl_on = 1'b0;
						nxt_state.analog = SLEEP_CFG_IN;
						nxt_state.hold = 1'b1;
					end else begin
						nxt_state.state = ST_DEEP_OFF;
						nxt_state.per_clk = 1'b0;
						nxt_state.wdt_clk = 1'b0;
						nxt_state.rc_on = 1'b0;
						nxt_state.rc_out = 1'b0;
						nxt_state.fl_on = 1'b0;
						nxt_state.analog = {CFG_WIDTH{1'b1}};
						nxt_state.tri_st = 1'b1;
						nxt_state.reg_on = 1'b0;
					end
				end
			end
			ST_SLEEP: begin
				if (IRQ_PENDING_IN) begin
					nxt_state.state = ST_ACTIVE;
					nxt_state.cpu_clk = 1'b1;
				end
			end
			ST_DEEP_SLEEP, ST_POWER_DOWN: begin
				if (wake_any) begin
					nxt_state.state = ST_ACTIVE;
					nxt_state.cpu_clk = 1'b1;
					nxt_state.per_clk = 1'b1;
					nxt_state.rc_on = 1'b1;
					nxt_state.rc_out = 1'b1;
					nxt_state.fl_on = 1'b1;
					nxt_state.fl_stby = 1'b0;
					nxt_state.hold = 1'b0;
					nxt_state.analog = WAKE_CFG_IN;
				end
			end
			ST_DEEP_OFF: begin
				if (state_ff.wake_prev && !WAKE_PIN_IN) begin
					nxt_state.state = ST_POR_RAMP;
					nxt_state.reg_on = 1'b1;
					nxt_state.por_cnt = 16'h0000;
				end
			end
			ST_POR_RAMP: begin
				nxt_state.por_cnt = state_ff.por_cnt + 16'h0001;
				if (state_ff.por_cnt == 16'(POR_CYC - 1)) begin
					nxt_state.state = ST_ACTIVE;
					nxt_state.mode = MODE_RESET;
					nxt_state.dpd_dis = 1'b0;
					nxt_state.analog = RUN_CFG_RESET;
					nxt_state.tri_st = 1'b0;
					nxt_state.hold = 1'b0;
					nxt_state.sys_rst = 1'b1;
					nxt_state.dpd_flag = 1'b1;
				end
			end
			default: nxt_state.state = ST_ACTIVE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// external reset is masked while powered off
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN || (EXT_RESET_IN && state_ff.state != ST_DEEP_OFF &&
			state_ff.state != ST_POR_RAMP)) begin
			state_ff <= '0;
			state_ff.state <= ST_ACTIVE;
			// mode field resets to sleep code
			state_ff.mode <= MODE_RESET;
			state_ff.wake_prev <= 1'b1;
			state_ff.cpu_clk <= 1'b1;
			state_ff.per_clk <= 1'b1;
			state_ff.wdt_clk <= 1'b1;
			state_ff.rc_on <= 1'b1;
			state_ff.rc_out <= 1'b1;
			state_ff.fl_on <= 1'b1;
			state_ff.reg_on <= 1'b1;
			state_ff.analog <= RUN_CFG_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign POWER_MODE_OUT    = state_ff.mode;
	assign DPD_DISABLE_OUT   = state_ff.dpd_dis;
	assign DPD_FLAG_OUT      = state_ff.dpd_flag;
	assign STATE_OUT         = state_ff.state;
	assign RETAIN_RD_OUT     = state_ff.rd;
	assign CPU_CLK_EN_OUT    = state_ff.cpu_clk;
	assign PERIPH_CLK_EN_OUT = state_ff.per_clk;
	assign WDT_CLK_EN_OUT    = state_ff.wdt_clk;
	assign RC_OSC_ON_OUT     = state_ff.rc_on;
	assign RC_OUT_EN_OUT     = state_ff.rc_out;
	assign FLASH_ON_OUT      = state_ff.fl_on;
	assign FLASH_STANDBY_OUT = state_ff.fl_stby;
	assign ANALOG_CFG_OUT    = state_ff.analog;
	assign PIN_HOLD_OUT      = state_ff.hold;
	assign PIN_TRISTATE_OUT  = state_ff.tri_st;
	assign CORE_REG_ON_OUT   = state_ff.reg_on;
	assign SYS_RESET_OUT     = state_ff.sys_rst;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_dpd_blocked: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		(state_ff.state == ST_ACTIVE && WAIT_INT_IN && DEEP_SLEEP_REQ_IN && state_ff.dpd_dis &&
		!EXT_RESET_IN) |=> state_ff.state != ST_DEEP_OFF)
		else $error("deep power-down entered while disabled");
	a_powerdown_gating: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		state_ff.state == ST_POWER_DOWN |-> !state_ff.rc_on && !state_ff.fl_on && !state_ff.cpu_clk)
		else $error("power-down left clocks or flash on");
	a_ds_gating: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		state_ff.state == ST_DEEP_SLEEP |-> state_ff.rc_on && !state_ff.rc_out && state_ff.fl_stby)
		else $error("deep sleep rc or flash wrong");
	a_dpd_tristate: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		state_ff.state == ST_DEEP_OFF |-> state_ff.tri_st && !state_ff.reg_on)
		else $error("deep power-down pins not tristated");
	a_ds_entry: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		(state_ff.state == ST_ACTIVE && WAIT_INT_IN && DEEP_SLEEP_REQ_IN && !EXT_RESET_IN &&
		state_ff.mode == MODE_DEEP_SLEEP) |=> state_ff.state == ST_DEEP_SLEEP)
		else $error("deep sleep not entered");
	a_wake_restore: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		(state_ff.state == ST_DEEP_SLEEP && wake_any && !EXT_RESET_IN) |=>
		state_ff.state == ST_ACTIVE && state_ff.analog == $past(WAKE_CFG_IN))
		else $error("wake config not restored");
	a_por_flag: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		$rose(state_ff.sys_rst) |-> state_ff.dpd_flag && state_ff.state == ST_ACTIVE)
		else $error("deep power-down flag not set on wake");
	a_hold_pins: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
		(state_ff.state == ST_DEEP_SLEEP || state_ff.state == ST_POWER_DOWN) |-> state_ff.hold)
		else $error("pins not held in deep sleep");

endmodule
`default_nettype wire

/* File: lpm_seq_pkg.sv */
package lpm_seq_pkg;

	// ----------------------------------------
	// power mode codes
	// ----------------------------------------
	localparam logic [1:0] MODE_SLEEP      = 2'h0;
	localparam logic [1:0] MODE_DEEP_SLEEP = 2'h1;
	localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
	localparam logic [1:0] MODE_DEEP_OFF   = 2'h3;
	localparam logic [1:0] MODE_RESET      = MODE_SLEEP;

	// ----------------------------------------
	// power control field positions
	// ----------------------------------------
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_DPD_BLOCK  = 3;
	localparam int CTRL_DPD_FLAG   = 11;
	localparam int WDT_LOCK_BIT    = 5;

	// ----------------------------------------
	// sleep / wake config bit positions
	// ----------------------------------------
	localparam int CFG_BROWNOUT_OFF = 0;
	localparam int CFG_WDOSC_OFF    = 1;
	localparam int CFG_WIDTH        = 8;
	localparam logic [CFG_WIDTH-1:0] RUN_CFG_RESET = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int POR_DELAY_NS    = 1000;
	localparam int POR_DELAY_CYC   = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETAIN_REGS     = 4;

	typedef enum logic [2:0] {
		ST_ACTIVE     = 3'b000,
		ST_SLEEP      = 3'b001,
		ST_DEEP_SLEEP = 3'b010,
		ST_POWER_DOWN = 3'b011,
		ST_DEEP_OFF   = 3'b100,
		ST_POR_RAMP   = 3'b101
	} lpm_state_e;

endpackage

/* File: lpm_wake_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module lpm_wake_detect
	import lpm_seq_pkg::*;
#(
	parameter int PINS = 8
) (
	// pin sources
	input  wire logic [PINS-1:0] pin_int_in,
	input  wire logic [PINS-1:0] pin_wake_enable_in,
	input  wire logic [PINS-1:0] pin_irq_en_in,
	// analog monitors, usb and gpio group
	input  wire logic            brownout_event_in,
	input  wire logic            brownout_int_en_in,
	input  wire logic            brownout_rst_en_in,
	input  wire logic            wdt_event_in,
	input  wire logic            wdt_int_mode_in,
	input  wire logic            wdt_reset_mode_in,
	input  wire logic            usb_wake_in,
	input  wire logic            gpio_group_in,
	input  wire logic [1:0]      wake_reg1_en_in,
	input  wire logic [CFG_WIDTH-1:0] sleep_cfg_in,
	// result
	output logic                 wake_out
);
	logic brownout_on;
	logic wdosc_on;
	logic pin_wake;
	logic brownout_wake;
	logic wdt_wake;
	logic aux_wake;

	assign pin_wake = |(pin_int_in & pin_wake_enable_in & pin_irq_en_in);
	assign brownout_on   = ~sleep_cfg_in[CFG_BROWNOUT_OFF];
	assign brownout_wake = brownout_on & brownout_event_in &
		(brownout_int_en_in | brownout_rst_en_in);
	// watchdog only with its oscillator running
	assign wdosc_on = ~sleep_cfg_in[CFG_WDOSC_OFF];
	assign wdt_wake = wdosc_on & wdt_event_in & (wdt_int_mode_in | wdt_reset_mode_in);
	assign aux_wake = (usb_wake_in & wake_reg1_en_in[0]) | (gpio_group_in & wake_reg1_en_in[1]);
	assign wake_out = pin_wake | brownout_wake | wdt_wake | aux_wake;
endmodule
`default_nettype wire

/* File: lpm_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lpm_core_model
	import lpm_seq_pkg::*;
(
	// clock
	input  wire logic clk_in,
	// power control writes
	output logic       ctrl_wr_out,
	output logic [1:0] mode_out,
	output logic       dpd_dis_out,
	output logic       flag_clr_out,
	// sleep handshake
	output logic       deep_req_out,
	output logic       wait_int_out
);
	initial begin
		ctrl_wr_out = 1'b0;
		mode_out = 2'h0;
		dpd_dis_out = 1'b0;
		flag_clr_out = 1'b0;
		deep_req_out = 1'b0;
		wait_int_out = 1'b0;
	end
	// mode code written before the wait
	task automatic write_ctrl(input logic [1:0] mode, input logic dis);
		@(negedge clk_in);
		ctrl_wr_out = 1'b1;
		mode_out = mode;
		dpd_dis_out = dis;
		@(negedge clk_in);
		ctrl_wr_out = 1'b0;
		// released data no longer shows the written value
		mode_out = ~mode;
		dpd_dis_out = ~dis;
	endtask
	// request bit then wait, main clock assumed on rc already
	task automatic do_sleep(input logic deep);
		@(negedge clk_in);
		deep_req_out = deep;
		wait_int_out = 1'b1;
		@(negedge clk_in);
		wait_int_out = 1'b0;
	endtask
	// flag read then cleared, clock reselect left to software
	task automatic clear_flag();
		@(negedge clk_in);
		flag_clr_out = 1'b1;
		@(negedge clk_in);
		flag_clr_out = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: test_low_power_mode_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_low_power_mode_sequencer;
	import lpm_seq_pkg::*;
	localparam int POR_T = 4;
	logic clk = 1'b0, srst = 1'b1, xrst = 1'b0, irq = 1'b0, lock = 1'b0, wrc = 1'b0;
	logic pwr, dis, fclr, dreq, wint;
	logic [1:0] mode, wen = 2'h0, ridx = 2'h0;
	logic [7:0] scfg = 8'h00, wcfg = 8'h00, pint = 8'h00, pen = 8'h00, pnv = 8'h00;
	logic brn = 1'b0, brni = 1'b0, brnr = 1'b0, wdt = 1'b0, wdti = 1'b0, wdtr = 1'b0;
	logic usb = 1'b0, gpio = 1'b0, wpin = 1'b1, rwr = 1'b0;
	logic [31:0] rdat = 32'h0, rsv, rrd;
	logic [1:0] mo;
	logic [2:0] st;
	logic [7:0] acfg;
	logic dout, fout, cpu, per, wck, rco, rce, fon, fsb, hold, tri_s, reg_on, sres;
	int failures = 0, compares = 0, cycles = 0, n;
	logic [1:0] m;
	logic w;
	always #5 clk = ~clk;
	lpm_core_model u_core (.clk_in(clk), .ctrl_wr_out(pwr), .mode_out(mode),
		.dpd_dis_out(dis), .flag_clr_out(fclr), .deep_req_out(dreq), .wait_int_out(wint));
	low_power_mode_sequencer #(.POR_CYC(POR_T)) u_dut (
		.CLOCK_IN(clk), .SRST_IN(srst), .EXT_RESET_IN(xrst), .CTRL_WR_IN(pwr),
		.POWER_MODE_IN(mode), .DPD_DISABLE_IN(dis), .DPD_FLAG_CLR_IN(fclr),
		.SLEEP_CFG_IN(scfg), .WAKE_CFG_IN(wcfg), .WDT_LOCK_IN(lock), .WDT_CLK_IS_RC_IN(wrc),
		.DEEP_SLEEP_REQ_IN(dreq), .WAIT_INT_IN(wint), .IRQ_PENDING_IN(irq), .PIN_INT_IN(pint),
		.PIN_WAKE_ENABLE_IN(pen), .PIN_IRQ_EN_IN(pnv), .BROWNOUT_EVENT_IN(brn),
		.BROWNOUT_INT_EN_IN(brni), .BROWNOUT_RST_EN_IN(brnr), .WDT_EVENT_IN(wdt),
		.WDT_INT_MODE_IN(wdti), .WDT_RESET_MODE_IN(wdtr), .USB_WAKE_IN(usb),
		.GPIO_GROUP_IN(gpio), .WAKE_REG1_EN_IN(wen), .WAKE_PIN_IN(wpin), .RETAIN_WR_IN(rwr),
		.RETAIN_IDX_IN(ridx), .RETAIN_DATA_IN(rdat), .POWER_MODE_OUT(mo),
		.DPD_DISABLE_OUT(dout), .DPD_FLAG_OUT(fout), .STATE_OUT(st), .RETAIN_RD_OUT(rrd),
		.CPU_CLK_EN_OUT(cpu), .PERIPH_CLK_EN_OUT(per), .WDT_CLK_EN_OUT(wck),
		.RC_OSC_ON_OUT(rco), .RC_OUT_EN_OUT(rce), .FLASH_ON_OUT(fon), .FLASH_STANDBY_OUT(fsb),
		.ANALOG_CFG_OUT(acfg), .PIN_HOLD_OUT(hold), .PIN_TRISTATE_OUT(tri_s),
		.CORE_REG_ON_OUT(reg_on), .SYS_RESET_OUT(sres));
	// ----
	// checking helpers
	// ----
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_state(input logic [2:0] exp, input int lim);
		n = 0;
		while (st !== exp && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("state", {29'h0, st}, {29'h0, exp});
	endtask
	function automatic logic [2:0] exp_state(input logic [1:0] c, input logic d);
		case (c)
			2'h1: return ST_DEEP_SLEEP;
			2'h2: return ST_POWER_DOWN;
			2'h3: return d ? ST_POWER_DOWN : ST_DEEP_OFF;
			default: return ST_SLEEP;
		endcase
	endfunction
	function automatic logic wake_exp();
		return |(pint & pen & pnv) | (!scfg[CFG_BROWNOUT_OFF] & brn & (brni | brnr))
			| (!scfg[CFG_WDOSC_OFF] & wdt & (wdti | wdtr)) | (usb & wen[0]) | (gpio & wen[1]);
	endfunction
	task automatic quiet();
		@(negedge clk);
		{pint, pen, pnv, brn, brni, brnr, wdt, wdti, wdtr, usb, gpio, wen, irq} = '0;
	endtask
	// clean wake through the usb line
	task automatic usb_wake();
		@(negedge clk);
		usb = 1'b1;
		wen = 2'h1;
		wait_state(ST_ACTIVE, 8);
		quiet();
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			failures++;
			test_done();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(49637));
		repeat (16) @(negedge clk);
		srst = 1'b0;
		check("mode", mo, MODE_RESET);
		check("flag", fout, 1'b0);
		$display("test reset done");
		// rc lock only tried in deep sleep, cleared before power-down
		for (int i = 0; i < 3; i++) begin
			m = 2'(i);
			scfg = 8'($urandom);
			wcfg = 8'($urandom);
			{lock, wrc} = {m == 2'h1, 1'b1};
			if (m == 2'h1) scfg[CFG_WDOSC_OFF] = 1'b1;
			u_core.write_ctrl(m, 1'b0);
			u_core.do_sleep(m != 2'h0);
			wait_state(exp_state(m, 1'b0), 4);
			check("cpu_clk", cpu, 1'b0);
			if (m != 2'h0) check("hold", hold, 1'b1);
			if (m == 2'h1) check("rc_gate", {rco, rce, fsb}, 3'b101);
			if (m == 2'h1) check("ds_wdt_clk", wck, !scfg[CFG_WDOSC_OFF] | (lock & wrc));
			if (m == 2'h2) check("pd_gate", {per, rco, fon}, 3'b000);
			if (m == 2'h2) check("wdt_clk", wck, !scfg[CFG_WDOSC_OFF]);
			if (m == 2'h0) begin
				@(negedge clk);
				irq = 1'b1;
				wait_state(ST_ACTIVE, 8);
				quiet();
			end else begin
				usb_wake();
				check("analog", acfg, wcfg);
			end
		end
		$display("test modes done");
		for (int i = 0; i < 24; i++) begin
			m = 2'($urandom_range(2, 1));
			scfg = {6'h00, 2'($urandom)};
			u_core.write_ctrl(m, 1'b0);
			u_core.do_sleep(1'b1);
			wait_state(exp_state(m, 1'b0), 4);
			@(negedge clk);
			pint = 8'h1 << $urandom_range(7, 0);
			{pen, pnv} = 16'($urandom);
			{brn, brni, brnr, wdt, wdti, wdtr} = 6'($urandom) & 6'($urandom);
			{usb, gpio, wen} = 4'($urandom) & 4'($urandom);
			w = wake_exp();
			repeat (4) @(negedge clk);
			check("wake", {29'h0, st}, w ? ST_ACTIVE : exp_state(m, 1'b0));
			quiet();
			if (!w) usb_wake();
		end
		$display("test wake sources done");
		u_core.write_ctrl(MODE_DEEP_OFF, 1'b1);
		u_core.do_sleep(1'b1);
		check("dpd_dis", dout, 1'b1);
		wait_state(ST_POWER_DOWN, 4);
		usb_wake();
		$display("test deep power-down refusal done");
		ridx = 2'($urandom);
		rsv = $urandom;
		@(negedge clk);
		rwr = 1'b1;
		rdat = rsv;
		@(negedge clk);
		rwr = 1'b0;
		rdat = ~rsv;
		u_core.write_ctrl(MODE_DEEP_OFF, 1'b0);
		u_core.do_sleep(1'b1);
		wait_state(ST_DEEP_OFF, 4);
		check("dpd_pins", {tri_s, reg_on}, 2'b10);
		xrst = 1'b1;
		repeat (2) @(negedge clk);
		xrst = 1'b0;
		check("dpd_xrst", {29'h0, st}, ST_DEEP_OFF);
		wpin = 1'b0;
		wait_state(ST_POR_RAMP, 3);
		check("reg_on", reg_on, 1'b1);
		n = 0;
		while (sres !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		check("ramp", n, POR_T);
		@(negedge clk);
		wpin = 1'b1;
		check("reboot", {st, mo, fout, tri_s, acfg},
			{ST_ACTIVE, MODE_RESET, 1'b1, 1'b0, RUN_CFG_RESET});
		repeat (2) @(negedge clk);
		check("retain", rrd, rsv);
		u_core.clear_flag();
		@(negedge clk);
		check("flag_clr", fout, 1'b0);
		$display("test deep power-down done");
		test_done();
	end
endmodule
`default_nettype wire
